// >>> hdl/emulated_phy_autoneg_regs.sv
/*
  Advertisement and emulated partner ability registers, reached over a
  32-bit register map port and over serial management (MDC/MDIO).
  Assumes the loader and negotiation logic share the clock; strap and
  duplex pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
module emulated_phy_autoneg_regs #(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input wire logic CLK_I,                                // 250 MHz clock
    input wire logic RST_B_I,                              // Async reset, low
    input wire logic [8:0] REG_ADDR_I,                     // Map byte address
    input wire logic REG_CS_I,                             // Map access strobe
    input wire logic REG_WE_I,                             // High for write
    input wire logic [31:0] REG_WDATA_I,                   // Map write data
    output logic [31:0] REG_RDATA_O,                       // Map read data
    output logic REG_RVALID_O,                             // Read data pulse
    input wire logic MDC_I,                                // Management clock
    input wire logic MDIO_I,                               // Management data in
    output logic MDIO_O,                                   // Management data out
    output logic MDIO_OE_O,                                // MDIO drive enable
    input wire logic LOAD_VALID_I,                         // Loader write pulse
    input wire logic [15:0] LOAD_DATA_I,                   // Loader image word
    input wire logic AN_DONE_I,                            // Negotiation done
    input wire autoneg_regs_pkg::strap_t STRAP_I,          // Strap and duplex pins
    output logic [15:0] ADVERT_O,                          // Advertisement value
    output logic [15:0] PARTNER_O,                         // Partner ability value
    output logic STRAPS_READY_O                            // Straps caught
);
    import autoneg_regs_pkg::*;

    typedef struct packed {
        strap_t s1;
        strap_t s2;
        logic [1:0] settle;
        logic ready;
        logic fresh;
        strap_t latched;
        logic [15:0] adv;
        logic [1:0] lp_pause;
        logic [3:0] lp_speed;
        logic [31:0] rdata;
        logic rvalid;
    } rst_t;

    rst_t r_ff, nxt_r;
    mgmt_req_t mreq;
    logic [15:0] mrdata;
    logic map_wr;
    logic [15:0] adv_rd;
    logic [15:0] lp_rd;

    // ==========================================================
    // Helpers

    // Partner {asym, sym} from local {asym, sym}
    function automatic logic [1:0] lp_pause_of(input logic [1:0] loc, input logic resolve);
        logic [1:0] res;
        res = 2'h0;
        case (loc)
            2'h0: res = 2'h0;
            2'h1: res = 2'h1;
            2'h2: res = 2'h3;
            2'h3: res = resolve ? 2'h3 : 2'h2;
            default: res = 2'h0;
        endcase
        return res;
    endfunction

    // Partner speed/duplex code for bits 8:5
    function automatic logic [3:0] lp_speed_of(input strap_t st);
        logic full;
        full = st.duplex_pin == st.duplex_pol;
        if (st.speed_100) begin
            return full ? LP_100_FULL : LP_100_HALF;
        end
        return full ? LP_10_FULL : LP_10_HALF;
    endfunction

    // Sixteen-bit view of a register by serial index
    function automatic logic [15:0] read16(input logic [4:0] idx, input logic [15:0] a,
                                           input logic [15:0] p);
        logic [15:0] v;
        v = 16'h0000;
        if (idx == IDX_ADVERT) v = a;
        if (idx == IDX_PARTNER) v = p;
        return v;
    endfunction

    // ==========================================================
    // Read views: fixed and reserved bits forced on every read
    assign adv_rd = r_ff.adv & ADV_WR_MASK;
    assign lp_rd = LP_FIXED
                   | {4'h0, r_ff.lp_pause[1], r_ff.lp_pause[0], 5'h00, 5'h00}
                   | {7'h00, r_ff.lp_speed, 5'h00};
    assign mrdata = read16(mreq.idx, adv_rd, lp_rd);

    assign map_wr = REG_CS_I & REG_WE_I & (REG_ADDR_I == OFS_ADVERT);

    // ==========================================================
    // Next-state logic
    always_comb begin
        nxt_r = r_ff;
        nxt_r.s1 = STRAP_I;
        nxt_r.s2 = r_ff.s1;
        nxt_r.fresh = 1'b0;
        nxt_r.rvalid = 1'b0;

        // Catch straps once the synchronisers hold post-reset levels
        if (!r_ff.ready) begin
            nxt_r.settle = r_ff.settle + 2'h1;
            if (r_ff.settle == STRAP_SETTLE) begin
                nxt_r.ready = 1'b1;
                nxt_r.fresh = 1'b1;
                nxt_r.latched = r_ff.s2;
                nxt_r.adv[ADV_ASYM_BIT] = ~r_ff.s2.flow_manual;
                nxt_r.adv[ADV_SYM_BIT] = ~r_ff.s2.flow_manual;
            end
        end

        // Write sources, lowest priority first; the map port wins
        if (LOAD_VALID_I) begin
            nxt_r.adv = LOAD_DATA_I & ADV_WR_MASK;
        end
        if (mreq.wr && mreq.idx == IDX_ADVERT) begin
            nxt_r.adv = mreq.wdata & ADV_WR_MASK;
        end
        if (map_wr) begin
            nxt_r.adv = REG_WDATA_I[15:0] & ADV_WR_MASK;
        end

        // Partner abilities frozen at each negotiation result
        if (AN_DONE_I || r_ff.fresh) begin
            nxt_r.lp_pause = lp_pause_of({adv_rd[ADV_ASYM_BIT], adv_rd[ADV_SYM_BIT]},
                                         r_ff.latched.pause_resolve);
            nxt_r.lp_speed = lp_speed_of('{flow_manual: r_ff.latched.flow_manual,
                                           pause_resolve: r_ff.latched.pause_resolve,
                                           duplex_pol: r_ff.latched.duplex_pol,
                                           speed_100: r_ff.latched.speed_100,
                                           duplex_pin: r_ff.s2.duplex_pin});
        end

        // Map read, answered one cycle later; upper half is padding
        if (REG_CS_I && !REG_WE_I) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rdata = 32'h0000_0000;
            if (REG_ADDR_I == OFS_ADVERT) nxt_r.rdata = {16'h0000, adv_rd};
            if (REG_ADDR_I == OFS_PARTNER) nxt_r.rdata = {16'h0000, lp_rd};
        end
    end

    // ==========================================================
    // State register; pause defaults replaced once straps are caught
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            r_ff <= '0;
            r_ff.adv <= ADV_RESET_BASE;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ==========================================================
    // Serial management path
    mgmt_serial_slave #(
        .PHY_ADDR(PHY_ADDR)
    ) u_serial (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .mdc_i(MDC_I),
        .mdio_i(MDIO_I),
        .mdio_o(MDIO_O),
        .mdio_oe_o(MDIO_OE_O),
        .req_o(mreq),
        .rdata_i(mrdata)
    );

    assign REG_RDATA_O = r_ff.rdata;
    assign REG_RVALID_O = r_ff.rvalid;
    assign ADVERT_O = r_ff.adv;
    assign PARTNER_O = lp_rd;
    assign STRAPS_READY_O = r_ff.ready;
endmodule

// >>> inc/autoneg_regs_pkg.sv
/*
  Constants, field layouts and carrier types for the emulated PHY
  auto-negotiation register pair and its serial management slave.
  Assumes a single 250 MHz clock and an asynchronous active-low reset.
*/
package autoneg_regs_pkg;

    // ==========================================================
    // Register map
    localparam int MAP_ADDR_W = 9;
    localparam logic [8:0] OFS_ADVERT = 9'h1D0;
    localparam logic [8:0] OFS_PARTNER = 9'h1D4;
    localparam logic [4:0] IDX_ADVERT = 5'h04;
    localparam logic [4:0] IDX_PARTNER = 5'h05;

    // ==========================================================
    // Advertisement fields
    localparam int ADV_ASYM_BIT = 11;
    localparam int ADV_SYM_BIT = 10;
    localparam logic [15:0] ADV_WR_MASK = 16'h0DFF;
    localparam logic [15:0] ADV_RESET_BASE = 16'h01E1;

    // ==========================================================
    // Partner fields
    localparam logic [15:0] LP_FIXED = 16'h4001;
    localparam int LP_PAUSE_LSB = 10;
    localparam int LP_SPEED_LSB = 5;
    localparam logic [3:0] LP_10_FULL = 4'h2;
    localparam logic [3:0] LP_100_FULL = 4'h8;
    localparam logic [3:0] LP_10_HALF = 4'h1;
    localparam logic [3:0] LP_100_HALF = 4'h4;

    // ==========================================================
    // Timing counts
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam int MDIO_PRE_LEN = 32;
    localparam int MDIO_HDR_BITS = 13;
    localparam int MDIO_DATA_BITS = 16;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic flow_manual;
        logic pause_resolve;
        logic duplex_pol;
        logic speed_100;
        logic duplex_pin;
    } strap_t;

    typedef struct packed {
        logic wr;
        logic [4:0] idx;
        logic [15:0] wdata;
    } mgmt_req_t;

endpackage

// >>> hdl/mgmt_serial_slave.sv
/*
  Serial management slave: frames on MDC/MDIO, gives a write request
  and a register index; returns read data from the caller's lookup.
  Assumes MDC is far slower than the clock; both pins are asynchronous.
*/
`timescale 1ns/1ns
module mgmt_serial_slave #(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input wire logic clk_i,                           // System clock
    input wire logic rst_b_i,                         // Async reset, low
    input wire logic mdc_i,                           // Management clock pin
    input wire logic mdio_i,                          // Management data in
    output logic mdio_o,                              // Management data out
    output logic mdio_oe_o,                           // High while driving
    output autoneg_regs_pkg::mgmt_req_t req_o,        // Write pulse, index
    input wire logic [15:0] rdata_i                   // Data for req_o.idx
);
    import autoneg_regs_pkg::*;

    typedef enum logic [3:0] {
        S_PRE = 4'b0001,
        S_HDR = 4'b0010,
        S_TA = 4'b0100,
        S_DAT = 4'b1000
    } mst_t;

    typedef struct packed {
        logic mdc_s1, mdc_s2, mdc_d;
        logic mdio_s1, mdio_s2;
        mst_t st;
        logic [5:0] cnt;
        logic [15:0] sh;
        logic is_rd, hit;
        logic out, oe;
        mgmt_req_t req;
    } sst_t;

    sst_t s_ff, nxt_s;
    logic rise;

    // ==========================================================
    // Frame engine, one step per MDC rising edge
    always_comb begin
        nxt_s = s_ff;
        nxt_s.mdc_s1 = mdc_i;
        nxt_s.mdc_s2 = s_ff.mdc_s1;
        nxt_s.mdc_d = s_ff.mdc_s2;
        nxt_s.mdio_s1 = mdio_i;
        nxt_s.mdio_s2 = s_ff.mdio_s1;
        nxt_s.req.wr = 1'b0;
        rise = s_ff.mdc_s2 & ~s_ff.mdc_d;
        if (rise) begin
            case (s_ff.st)
                S_PRE: begin
                    // Preamble suppression not accepted: full run of ones needed
                    if (s_ff.mdio_s2) begin
                        if (s_ff.cnt != 6'(MDIO_PRE_LEN)) nxt_s.cnt = s_ff.cnt + 6'h01;
                    end else begin
                        if (s_ff.cnt == 6'(MDIO_PRE_LEN)) begin
                            nxt_s.st = S_HDR;
                        end
                        nxt_s.cnt = 6'h00;
                    end
                end
                S_HDR: begin
                    nxt_s.sh = {s_ff.sh[14:0], s_ff.mdio_s2};
                    nxt_s.cnt = s_ff.cnt + 6'h01;
                    if (s_ff.cnt == 6'(MDIO_HDR_BITS - 1)) begin
                        nxt_s.cnt = 6'h00;
                        nxt_s.st = S_TA;
                        // Twelve bits held: start low bit at 11, opcode 10:9, address 8:4
                        nxt_s.req.idx = {s_ff.sh[3:0], s_ff.mdio_s2};
                        nxt_s.is_rd = s_ff.sh[10:9] == 2'h2;
                        nxt_s.hit = s_ff.sh[11] && s_ff.sh[8:4] == PHY_ADDR
                                    && s_ff.sh[10] != s_ff.sh[9];
                        if (!s_ff.sh[11]) nxt_s.st = S_PRE;
                    end
                end
                S_TA: begin
                    nxt_s.cnt = s_ff.cnt + 6'h01;
                    if (s_ff.cnt == 6'h00) begin
                        // Second turnaround bit is driven low on reads
                        nxt_s.oe = s_ff.is_rd & s_ff.hit;
                        nxt_s.out = 1'b0;
                        nxt_s.sh = rdata_i;
                    end else begin
                        nxt_s.cnt = 6'h00;
                        nxt_s.st = S_DAT;
                        nxt_s.out = s_ff.sh[15];
                        nxt_s.sh = {s_ff.sh[14:0], 1'b0};
                    end
                end
                S_DAT: begin
                    nxt_s.cnt = s_ff.cnt + 6'h01;
                    if (s_ff.is_rd) begin
                        nxt_s.out = s_ff.sh[15];
                        nxt_s.sh = {s_ff.sh[14:0], 1'b0};
                    end else begin
                        nxt_s.sh = {s_ff.sh[14:0], s_ff.mdio_s2};
                    end
                    if (s_ff.cnt == 6'(MDIO_DATA_BITS - 1)) begin
                        nxt_s.st = S_PRE;
                        nxt_s.cnt = 6'h00;
                        nxt_s.oe = 1'b0;
                        nxt_s.out = 1'b0;
                        nxt_s.req.wr = ~s_ff.is_rd & s_ff.hit;
                        nxt_s.req.wdata = {s_ff.sh[14:0], s_ff.mdio_s2};
                    end
                end
                default: begin
                    nxt_s.st = S_PRE;
                    nxt_s.cnt = 6'h00;
                    nxt_s.oe = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_ff <= '{st: S_PRE, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign mdio_o = s_ff.out;
    assign mdio_oe_o = s_ff.oe;
    assign req_o = s_ff.req;
endmodule

// >>> bench/emulated_phy_autoneg_regs_properties.sv
/*
  Checker for the advertisement and partner registers, on top ports only.
  Assumes straps hold still between resets and one write source a cycle.
*/
`timescale 1ns/1ns
module emulated_phy_autoneg_regs_properties (
    input wire logic CLK_I, // Clock
    input wire logic RST_B_I, // Reset, low
    input wire logic [8:0] REG_ADDR_I, // Map address
    input wire logic REG_CS_I, // Map strobe
    input wire logic REG_WE_I, // Write flag
    input wire logic [31:0] REG_WDATA_I, // Write data
    input wire logic [31:0] REG_RDATA_O, // Read data
    input wire logic REG_RVALID_O, // Read pulse
    input wire logic LOAD_VALID_I, // Loader pulse
    input wire logic [15:0] LOAD_DATA_I, // Loader word
    input wire logic AN_DONE_I, // Negotiation done
    input wire autoneg_regs_pkg::strap_t STRAP_I, // Straps
    input wire logic [15:0] ADVERT_O, // Advertisement
    input wire logic [15:0] PARTNER_O, // Partner view
    input wire logic STRAPS_READY_O // Straps caught
);
    import autoneg_regs_pkg::*;
    // ====================
    // Expected partner fields, one edge behind their cause
    logic [1:0] pause_exp_ff;
    logic [3:0] speed_exp_ff;
    logic full;
    assign full = STRAP_I.duplex_pin == STRAP_I.duplex_pol;
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pause_exp_ff <= 2'h0;
            speed_exp_ff <= 4'h0;
        end else begin
            pause_exp_ff <= (ADVERT_O[11:10] == 2'h3) ? {1'b1, STRAP_I.pause_resolve} :
                (ADVERT_O[11:10] == 2'h2) ? 2'h3 : ADVERT_O[11:10];
            speed_exp_ff <= {STRAP_I.speed_100 & full, STRAP_I.speed_100 & !full,
                !STRAP_I.speed_100 & full, !STRAP_I.speed_100 & !full};
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // ====================
    // Map answers and fixed bits
    a_read_answer:
        assert property (REG_CS_I && !REG_WE_I |=> REG_RVALID_O)
        else $error("read strobe not answered");
    a_no_stray_valid:
        assert property (!(REG_CS_I && !REG_WE_I) |=> !REG_RVALID_O)
        else $error("read pulse without strobe");
    a_pad_zero:
        assert property (REG_RVALID_O |-> REG_RDATA_O[31:16] == 16'h0000)
        else $error("padding not zero");
    a_adv_readback:
        assert property (REG_RVALID_O && $past(REG_ADDR_I) == OFS_ADVERT
            |-> REG_RDATA_O == {16'h0000, $past(ADVERT_O)})
        else $error("advert read data wrong");
    a_adv_fixed:
        assert property ((ADVERT_O & 16'hF200) == 16'h0000)
        else $error("advert fixed bit set");
    a_lp_fixed:
        assert property ((PARTNER_O & 16'hF21F) == 16'h4001)
        else $error("partner fixed bits wrong");
    // ====================
    // Write sources and partner capture
    a_map_write:
        assert property (REG_CS_I && REG_WE_I && REG_ADDR_I == OFS_ADVERT && STRAPS_READY_O
            |=> ADVERT_O == (16'h0DFF & $past(REG_WDATA_I[15:0])))
        else $error("map write not applied");
    a_load_write:
        assert property (LOAD_VALID_I && !(REG_CS_I && REG_WE_I) && STRAPS_READY_O
            |=> ADVERT_O == (16'h0DFF & $past(LOAD_DATA_I)))
        else $error("loader write not applied");
    a_lp_frozen:
        assert property ($past(STRAPS_READY_O, 2) && !$past(AN_DONE_I) |-> $stable(PARTNER_O))
        else $error("partner changed without negotiation");
    a_lp_pause:
        assert property (AN_DONE_I |=> PARTNER_O[11:10] == pause_exp_ff)
        else $error("partner pause wrong");
    a_lp_speed:
        assert property (AN_DONE_I |=> PARTNER_O[8:5] == speed_exp_ff)
        else $error("partner speed wrong");
    a_pause_default:
        assert property ($rose(STRAPS_READY_O) |-> ADVERT_O[11:10] == {2{!STRAP_I.flow_manual}})
        else $error("pause default wrong");
endmodule
bind emulated_phy_autoneg_regs emulated_phy_autoneg_regs_properties chk (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .REG_ADDR_I(REG_ADDR_I), .REG_CS_I(REG_CS_I),
    .REG_WE_I(REG_WE_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
    .REG_RVALID_O(REG_RVALID_O), .LOAD_VALID_I(LOAD_VALID_I), .LOAD_DATA_I(LOAD_DATA_I),
    .AN_DONE_I(AN_DONE_I), .STRAP_I(STRAP_I), .ADVERT_O(ADVERT_O), .PARTNER_O(PARTNER_O),
    .STRAPS_READY_O(STRAPS_READY_O)
);

// >>> bench/mgmt_host_model.sv
/*
  Management station model: sends serial frames on MDC and MDIO.
  Assumes the bench resolves the shared MDIO line with a pull-up.
*/
`timescale 1ns/1ns
module mgmt_host_model #(
    parameter int HALF = 8
) (
    input wire logic clk_i, // System clock
    input wire logic mdio_i, // Resolved MDIO line
    output logic mdc_o, // Management clock
    output logic mdio_o, // Data driven
    output logic mdio_oe_o // High while driving
);
    // MDC stands low between frames
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b0;
        mdio_oe_o = 1'b0;
    end
    // One MDC period; the line is sampled just before the rise
    task automatic clk_bit(input logic d, input logic drv, output logic q);
        @(posedge clk_i);
        mdio_o <= d;
        mdio_oe_o <= drv;
        repeat (HALF) @(posedge clk_i);
        q = mdio_i;
        mdc_o <= 1'b1;
        repeat (HALF) @(posedge clk_i);
        mdc_o <= 1'b0;
    endtask
    // Whole frame with fresh preamble; released for read turnaround
    task automatic frame(input logic wr, input logic [4:0] phy, input logic [4:0] idx,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic q;
        int i;
        hdr = {2'b01, !wr, wr, phy, idx};
        rd = 16'h0000;
        for (i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, q);
        for (i = 13; i >= 0; i--) clk_bit(hdr[i], 1'b1, q);
        clk_bit(1'b1, wr, q);
        clk_bit(1'b0, wr, q);
        for (i = 15; i >= 0; i--) begin
            clk_bit(wd[i], wr, q);
            rd = {rd[14:0], q};
        end
        @(posedge clk_i);
        mdio_oe_o <= 1'b0;
        repeat (4 * HALF) @(posedge clk_i);
    endtask
endmodule

// >>> bench/tb_emulated_phy_autoneg_regs.sv
/*
  Testbench for the auto-negotiation register pair over map and serial.
  Assumes the design's default PHY address of zero.
*/
`timescale 1ns/1ns
module tb_emulated_phy_autoneg_regs;
    import autoneg_regs_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [8:0] addr = 9'h000;
    logic cs = 1'b0;
    logic we = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic load_valid = 1'b0;
    logic [15:0] load_data = 16'h0;
    logic an_done = 1'b0;
    strap_t straps = 5'h00;
    logic [31:0] rdata;
    logic [15:0] advert, partner, srd;
    logic rvalid, mdc, host_d, host_oe, dut_d, dut_oe, mdio_line, ready;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int p;
    always #2 clk = ~clk;
    // Shared MDIO with pull-up when nobody drives
    assign mdio_line = dut_oe ? dut_d : (host_oe ? host_d : 1'b1);
    emulated_phy_autoneg_regs dut (
        .CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_CS_I(cs),
        .REG_WE_I(we), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .MDC_I(mdc), .MDIO_I(mdio_line), .MDIO_O(dut_d), .MDIO_OE_O(dut_oe),
        .LOAD_VALID_I(load_valid), .LOAD_DATA_I(load_data), .AN_DONE_I(an_done),
        .STRAP_I(straps), .ADVERT_O(advert), .PARTNER_O(partner), .STRAPS_READY_O(ready)
    );
    mgmt_host_model host (
        .clk_i(clk), .mdio_i(mdio_line), .mdc_o(mdc), .mdio_o(host_d), .mdio_oe_o(host_oe)
    );
    // ====================
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic map_wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        cs <= 1'b1;
        we <= 1'b1;
        wdata <= d;
        @(posedge clk);
        cs <= 1'b0;
        we <= 1'b0;
    endtask
    // Read answer lands on the same edge that takes the strobe
    task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        cs <= 1'b1;
        @(posedge clk);
        cs <= 1'b0;
        // Look while the one-cycle pulse stands, away from its launching edge
        @(negedge clk);
        cmp({31'h0, rvalid}, 32'h1);
        cmp(rdata, exp);
        @(posedge clk);
    endtask
    task automatic do_reset(input strap_t s);
        @(posedge clk);
        rst_b <= 1'b0;
        straps <= s;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic an_pulse();
        @(posedge clk);
        an_done <= 1'b1;
        @(posedge clk);
        an_done <= 1'b0;
    endtask
    // Partner pause {asym,sym} from local pause, worked out here
    function automatic logic [1:0] lp_pause(input logic [1:0] adv, input logic res);
        if (adv == 2'h3) return {1'b1, res};
        return (adv == 2'h2) ? 2'h3 : adv;
    endfunction
    // ====================
    initial begin
        // Run 1: pause advertised, 100M, resolve low
        do_reset(5'b0_0_0_1_0);
        cmp({31'h0, ready}, 32'h1);
        rd_chk(OFS_ADVERT, 32'h0000_0DE1);
        rd_chk(OFS_PARTNER, 32'h0000_4901);
        map_wr(OFS_ADVERT, 32'hFFFF_FFFF);
        rd_chk(OFS_ADVERT, 32'h0000_0DFF);
        map_wr(OFS_PARTNER, 32'h0000_0000);
        rd_chk(OFS_PARTNER, 32'h0000_4901);
        rd_chk(9'h1D8, 32'h0000_0000);
        // Every local pause pairing, duplex pin toggled alongside
        for (p = 0; p < 4; p++) begin
            straps.duplex_pin <= p[0];
            map_wr(OFS_ADVERT, {20'h0, p[1:0], 10'h1E1});
            an_pulse();
            rd_chk(OFS_PARTNER, {16'h0, 4'h4, lp_pause(p[1:0], 1'b0), 1'b0,
                p[0] ? 4'h4 : 4'h8, 5'h01});
        end
        // Loader image, reserved bits dropped
        @(posedge clk);
        load_data <= 16'hF461;
        load_valid <= 1'b1;
        @(posedge clk);
        load_valid <= 1'b0;
        @(posedge clk);
        cmp({16'h0, advert}, 32'h0000_0461);
        // Serial write and reads, then frames that must be refused or read as zero
        host.frame(1'b1, 5'h00, IDX_ADVERT, 16'h0521, srd);
        rd_chk(OFS_ADVERT, 32'h0000_0521);
        host.frame(1'b0, 5'h00, IDX_ADVERT, 16'h0000, srd);
        cmp({16'h0, srd}, 32'h0000_0521);
        host.frame(1'b0, 5'h00, IDX_PARTNER, 16'h0000, srd);
        cmp({16'h0, srd}, 32'h0000_4881);
        host.frame(1'b1, 5'h1F, IDX_ADVERT, 16'h0DE1, srd);
        host.frame(1'b0, 5'h1F, IDX_ADVERT, 16'h0000, srd);
        cmp({16'h0, srd}, 32'h0000_FFFF);
        host.frame(1'b0, 5'h00, 5'h06, 16'h0000, srd);
        cmp({16'h0, srd}, 32'h0000_0000);
        host.frame(1'b1, 5'h00, IDX_PARTNER, 16'h0000, srd);
        rd_chk(OFS_ADVERT, 32'h0000_0521);
        rd_chk(OFS_PARTNER, 32'h0000_4881);
        // Run 2: pause off, 10M, resolve high, inverted polarity
        do_reset(5'b1_1_1_0_1);
        rd_chk(OFS_ADVERT, 32'h0000_01E1);
        rd_chk(OFS_PARTNER, 32'h0000_4041);
        straps.duplex_pin <= 1'b0;
        map_wr(OFS_ADVERT, 32'h0000_0DE1);
        an_pulse();
        rd_chk(OFS_PARTNER, 32'h0000_4C21);
        test_done();
    end
    // Hang guard, far above the roughly eight thousand cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            test_done();
        end
    end
endmodule
